// ---- rtl/nand_cmd_seq.sv ----
// NAND command sequencer with slow-clock waveforms and wait input handling
`timescale 1ns/1ns
// Notes on behaviour
// - Pulse shorter than wait latency plus three cycles may miss the wait assertion.
// - Slow-clock indication replaces programmed waveforms by fixed ones, no reprogramming.
// - Slow-clock waveforms apply on every chip select.
// - Slow read: setup 1, pulse 1, select setup 0, select pulse 2, cycle 2.
// - Slow write: setup 1, pulse 1, select setup 0, select pulse 3, cycle 3.
// - Strobe cycle under way keeps its waveform set when slow clock ends.
// - Controller sends command, address bytes and moves page data itself.
// - One write: address holds command, data holds address bytes; starts once the sequencer is idle.
// - Command writes are posted and acknowledged with no wait.
// - Command window decodes from the command-enabled external base upward.
// - Any read in the window returns controller status.
// - Command word field layout from bit 27 down to bit 2.
// - Command enable sends the first command byte in the first latch cycle.
// - Nonzero address count gives exactly that many address cycles, at most five.
// - Second command byte after addresses only when enabled and valid.
// - Transfer enable adds the page data transfer after the commands.
// - Direction bit: zero reads from device, one writes to device.
// - Under five cycles the data bytes go lowest first.
// - Five cycles: byte zero comes from its own register, then data bytes.
// - Command byte is driven on the data bus during its latch cycle.
// - Status mirrors command layout with busy at bit 27, reset zero.
// - Busy reads one while a command or transfer runs.
// - Wait input is looked at only during the strobe pulse phase.
module nand_cmd_seq
  import nand_seq_pkg::*;
#(
  parameter int PAGE_BYTES = 4096,
  parameter int AW         = $clog2(PAGE_BYTES)
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Command window access
  input  wire host_req_s     host_req,
  output host_rsp_s          host_rsp,
  // Configuration
  input  wire smc_cfg_s      cfg,
  input  wire logic          slow_clock_mode,
  input  wire logic [7:0]    address_byte_zero,
  // Page buffer user port, usable while not busy
  input  wire logic [AW-1:0] buf_addr,
  input  wire logic          buf_we,
  input  wire logic [7:0]    buf_wdata,
  output logic      [7:0]    buf_rdata,
  // NAND and external device pins
  input  wire logic          external_wait_in_n,
  input  wire logic [7:0]    nand_io_in,
  output nand_pins_s         nand_pins,
  output logic               busy
);

  typedef struct packed {
    seq_e          seq;
    logic [31:0]   cmd;
    logic [31:0]   adt;
    logic          pend;
    logic [31:0]   pcmd;
    logic [31:0]   padt;
    logic [2:0]    aidx;
    logic [AW-1:0] didx;
    logic          cyc;
    logic          gap;
    logic          rd;
    logic          slow;
    wave_s         w;
    logic [1:0]    wmode;
    logic [7:0]    cnt;
    logic [7:0]    io;
    logic          ws1;
    logic          ws2;
    logic [7:0]    is1;
    logic [7:0]    is2;
    nand_pins_s    pins;
    host_rsp_s     rsp;
  } st_s;

  localparam st_s ST_RESET = '{
    seq: ST_IDLE, cmd: CMD_WORD_RESET, adt: ADDR_BYTES_RESET, pcmd: CMD_WORD_RESET,
    padt: ADDR_BYTES_RESET, ws1: 1'b1, ws2: 1'b1,
    pins: '{1'b0, 1'b0, 1'b1, 1'b1, 8'hff, 8'h00, 1'b0},
    rsp: '{1'b0, STATUS_RESET}, default: '0};

  st_s           s;
  st_s           next_s;
  logic          done;
  logic          free;
  logic          in_pulse;
  logic          advance;
  logic [AW-1:0] mem_addr;
  logic          mem_we;
  logic [7:0]    mem_wdata;
  logic [7:0]    mem_rdata;

  // Address count, clamped to the supported maximum
  function automatic logic [2:0] acyc_of(input logic [31:0] c);
    logic [2:0] a;
    a = c[ACYC_HI:ACYC_LO];
    return (a > MAX_ADDR_CYCLES) ? MAX_ADDR_CYCLES : a;
  endfunction

  // Step that follows the given one for command word c
  function automatic seq_e after(input seq_e cur, input logic [31:0] c);
    if (cur == ST_IDLE && c[CMD_EN_BIT]) begin
      return ST_FIRST_COMMAND_BYTE;
    end
    if ((cur == ST_IDLE || cur == ST_FIRST_COMMAND_BYTE) && acyc_of(c) != 3'h0) begin
      return ST_ADDR;
    end
    if (cur != ST_SECOND_COMMAND_BYTE && cur != ST_DATA && c[CMD_EN_BIT] && c[SECOND_COMMAND_BYTE_VALID_BIT]) begin
      return ST_SECOND_COMMAND_BYTE;
    end
    if (cur != ST_DATA && c[XFER_EN_BIT]) begin
      return ST_DATA;
    end
    return ST_IDLE;
  endfunction

  // Address byte for cycle i
  function automatic logic [7:0] addr_byte(input logic [31:0] c, input logic [31:0] d,
                                           input logic [2:0] i, input logic [7:0] z);
    logic [2:0] k;
    k = i;
    if (acyc_of(c) == MAX_ADDR_CYCLES) begin
      if (i == 3'h0) begin
        return z;
      end
      k = i - 3'h1;
    end
    return d[{k[1:0], 3'h0} +: 8];
  endfunction

  // Whether counter value n lies in [start, start+len)
  function automatic logic in_span(input logic [7:0] n, input logic [7:0] start,
                                   input logic [7:0] len);
    return ({1'b0, n} >= {1'b0, start}) && ({1'b0, n} < ({1'b0, start} + {1'b0, len}));
  endfunction

  // Pin levels for a state
  function automatic nand_pins_s pins_of(input st_s x);
    nand_pins_s p;
    logic       str;
    logic       sel;
    str = x.cyc && in_span(x.cnt, x.w.setup, x.w.pulse);
    sel = x.cyc && in_span(x.cnt, x.w.cs_setup, x.w.cs_pulse);
    p.cle                  = x.cyc && (x.seq == ST_FIRST_COMMAND_BYTE || x.seq == ST_SECOND_COMMAND_BYTE);
    p.ale                  = x.cyc && x.seq == ST_ADDR;
    p.read_strobe_n        = !(str && x.rd);
    p.write_strobe_n       = !(str && !x.rd);
    p.chip_select_strobe_n = sel ? ~(8'h01 << x.cmd[CS_HI:CS_LO]) : 8'hff;
    p.io_out               = x.io;
    p.io_oe                = x.cyc && !x.rd;
    return p;
  endfunction

  // Status word: command layout with busy in the enable position
  function automatic logic [31:0] status_of(input st_s x, input logic b);
    return {4'h0, b, x.cmd[WR_DIR_BIT:FIRST_COMMAND_BYTE_LO], 2'h0};
  endfunction

  assign busy      = (s.seq != ST_IDLE) || s.cyc || s.gap || s.pend;
  assign nand_pins = s.pins;
  assign host_rsp  = s.rsp;
  assign buf_rdata = mem_rdata;

  // Next state: host window, strobe engine, step sequencer, pins
  always_comb begin
    next_s   = s;
    done     = 1'b0;
    in_pulse = s.cyc && in_span(s.cnt, s.w.setup, s.w.pulse);
    advance  = 1'b1;
    free     = !s.cyc && !s.gap;
    mem_addr = s.didx;
    mem_we   = 1'b0;
    mem_wdata = s.is2;

    // Pin resynchronisers
    next_s.ws1 = external_wait_in_n;
    next_s.ws2 = s.ws1;
    next_s.is1 = nand_io_in;
    next_s.is2 = s.is1;

    // Posted command writes and status reads, answered next cycle
    next_s.rsp.ack   = host_req.req;
    next_s.rsp.rdata = s.rsp.rdata;
    if (host_req.req && host_req.addr[31:WINDOW_LSB] == CMD_WINDOW_BASE[31:WINDOW_LSB]) begin
      if (host_req.wr) begin
        if (!s.pend) begin
          next_s.pend = 1'b1;
          next_s.pcmd = host_req.addr;
          next_s.padt = host_req.wdata;
        end
      end else begin
        next_s.rsp.rdata = status_of(s, busy);
      end
    end else if (host_req.req && !host_req.wr) begin
      next_s.rsp.rdata = 32'h0;
    end

    // Strobe engine; wait input only acts during the pulse phase
    if (s.cyc) begin
      if (s.wmode == WAIT_MODE_FROZEN && in_pulse && !s.ws2) begin
        advance = 1'b0;
      end
      if (s.wmode == WAIT_MODE_READY && in_pulse && !s.ws2 &&
          ({1'b0, s.cnt} + 9'd1 == {1'b0, s.w.setup} + {1'b0, s.w.pulse})) begin
        advance = 1'b0;
      end
      if (advance) begin
        if ({1'b0, s.cnt} + 9'd1 >= {1'b0, s.w.cycle}) begin
          done       = 1'b1;
          next_s.cyc = 1'b0;
          next_s.gap = 1'b1;
          next_s.cnt = 8'h00;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
    end else begin
      next_s.gap = 1'b0;
    end

    // Step completion
    if (done) begin
      case (s.seq)
        ST_ADDR: begin
          next_s.aidx = s.aidx + 3'h1;
          if (s.aidx + 3'h1 == acyc_of(s.cmd)) begin
            next_s.seq = after(ST_ADDR, s.cmd);
          end
        end
        ST_DATA: begin
          if (s.rd) begin
            mem_we = 1'b1;
          end
          next_s.didx = s.didx + AW'(1);
          if (s.didx == AW'(PAGE_BYTES - 1)) begin
            next_s.seq = ST_IDLE;
          end
        end
        ST_FIRST_COMMAND_BYTE: next_s.seq = after(ST_FIRST_COMMAND_BYTE, s.cmd);
        ST_SECOND_COMMAND_BYTE: next_s.seq = after(ST_SECOND_COMMAND_BYTE, s.cmd);
        default: next_s.seq = ST_IDLE;
      endcase
    end

    // Step launch: waveform set is latched per cycle and kept to its end
    if (free && s.seq == ST_IDLE && s.pend) begin
      next_s.pend = 1'b0;
      next_s.cmd  = s.pcmd;
      next_s.adt  = s.padt;
      next_s.aidx = 3'h0;
      next_s.didx = '0;
      next_s.seq  = after(ST_IDLE, s.pcmd);
    end else if (free && s.seq != ST_IDLE) begin
      next_s.cyc   = 1'b1;
      next_s.cnt   = 8'h00;
      next_s.slow  = slow_clock_mode;
      next_s.rd    = (s.seq == ST_DATA) && !s.cmd[WR_DIR_BIT];
      next_s.wmode = slow_clock_mode ? WAIT_MODE_OFF : cfg.wait_input_mode;
      if (slow_clock_mode) begin
        next_s.w = next_s.rd ? SLOW_READ_WAVE : SLOW_WRITE_WAVE;
      end else begin
        next_s.w = next_s.rd ? cfg.rd : cfg.wr;
      end
      case (s.seq)
        ST_FIRST_COMMAND_BYTE: next_s.io = s.cmd[FIRST_COMMAND_BYTE_HI:FIRST_COMMAND_BYTE_LO];
        ST_SECOND_COMMAND_BYTE: next_s.io = s.cmd[SECOND_COMMAND_BYTE_HI:SECOND_COMMAND_BYTE_LO];
        ST_ADDR: next_s.io = addr_byte(s.cmd, s.adt, s.aidx, address_byte_zero);
        ST_DATA: next_s.io = mem_rdata;
        default: next_s.io = 8'h00;
      endcase
    end

    // Page buffer belongs to the user while idle
    if (!busy) begin
      mem_addr  = buf_addr;
      mem_we    = buf_we;
      mem_wdata = buf_wdata;
    end

    next_s.pins = pins_of(next_s);
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Page buffer
  page_ram #(
    .DEPTH (PAGE_BYTES),
    .AW    (AW)
  ) u_page_ram (
    .mclk  (mclk),
    .addr  (mem_addr),
    .we    (mem_we),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_status_read;
    host_req.req && !host_req.wr &&
      host_req.addr[31:WINDOW_LSB] == CMD_WINDOW_BASE[31:WINDOW_LSB];
  endsequence

  sequence s_cmd_launch;
    free && s.seq == ST_FIRST_COMMAND_BYTE;
  endsequence

  a_status_busy_bit: assert property (s_status_read |=>
    host_rsp.rdata[BUSY_BIT] == $past(busy))
    else $error("status busy bit does not match busy state");
  a_posted_ack: assert property (host_req.req |=> host_rsp.ack)
    else $error("command window access not acknowledged next cycle");
  a_first_command_byte_on_bus: assert property (s_cmd_launch |=>
    nand_pins.cle && nand_pins.io_out == $past(s.cmd[FIRST_COMMAND_BYTE_HI:FIRST_COMMAND_BYTE_LO]) && nand_pins.io_oe)
    else $error("first command byte not driven in its latch cycle");
  a_slow_read_len: assert property (s.cyc && s.slow && s.rd |->
    s.cnt < 8'h02 && s.w == SLOW_READ_WAVE)
    else $error("slow read cycle longer than two cycles");
  a_slow_write_len: assert property (s.cyc && s.slow && !s.rd |->
    s.cnt < 8'h03 && s.w == SLOW_WRITE_WAVE)
    else $error("slow write cycle longer than three cycles");
  a_wait_outside_pulse: assert property (s.cyc && !in_pulse |=>
    (s.cnt != $past(s.cnt)) || !s.cyc)
    else $error("engine stalled outside the strobe pulse");
  a_addr_count_exact: assert property (done && s.seq == ST_ADDR &&
    s.aidx + 3'h1 == acyc_of(s.cmd) |=> s.seq != ST_ADDR ##1 !nand_pins.ale)
    else $error("address cycles do not stop at the programmed count");
  a_second_command_byte_gated: assert property (s.seq == ST_SECOND_COMMAND_BYTE |->
    s.cmd[CMD_EN_BIT] && s.cmd[SECOND_COMMAND_BYTE_VALID_BIT])
    else $error("second command issued without enable and valid");
  a_data_direction: assert property (s.cyc && s.seq == ST_DATA |->
    s.rd == !s.cmd[WR_DIR_BIT])
    else $error("data strobe direction does not follow direction bit");

endmodule

// ---- rtl/nand_seq_pkg.sv ----
// Shared constants and carrier types for the NAND command sequencer
package nand_seq_pkg;

  // Command window placement
  localparam logic [31:0] EXT_MEM_BASE    = 32'h6000_0000;
  localparam int          CMD_EN_BIT      = 27;
  localparam logic [31:0] CMD_WINDOW_BASE = EXT_MEM_BASE | (32'h1 << CMD_EN_BIT);
  localparam int          WINDOW_LSB      = 27;

  // Command word fields
  localparam int WR_DIR_BIT     = 26;
  localparam int XFER_EN_BIT    = 25;
  localparam int CS_HI          = 24;
  localparam int CS_LO          = 22;
  localparam int ACYC_HI        = 21;
  localparam int ACYC_LO        = 19;
  localparam int SECOND_COMMAND_BYTE_VALID_BIT = 18;
  localparam int SECOND_COMMAND_BYTE_HI        = 17;
  localparam int SECOND_COMMAND_BYTE_LO        = 10;
  localparam int FIRST_COMMAND_BYTE_HI        = 9;
  localparam int FIRST_COMMAND_BYTE_LO        = 2;
  localparam int BUSY_BIT       = 27;

  // Reset values
  localparam logic [31:0] CMD_WORD_RESET   = 32'h0000_0000;
  localparam logic [31:0] ADDR_BYTES_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

  // Address cycle limit
  localparam logic [2:0] MAX_ADDR_CYCLES = 3'h5;

  // Wait input resynchronisation and least pulse margin
  localparam int RESYNC_CYCLES     = 2;
  localparam int WAIT_EXTRA_CYCLES = 1;

  // Wait input modes
  localparam logic [1:0] WAIT_MODE_OFF    = 2'h0;
  localparam logic [1:0] WAIT_MODE_FROZEN = 2'h2;
  localparam logic [1:0] WAIT_MODE_READY  = 2'h3;

  // One strobe waveform, all in master clock cycles
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] pulse;
    logic [7:0] cs_setup;
    logic [7:0] cs_pulse;
    logic [7:0] cycle;
  } wave_s;

  // Fixed slow-clock waveforms
  localparam wave_s SLOW_READ_WAVE  = '{8'h01, 8'h01, 8'h00, 8'h02, 8'h02};
  localparam wave_s SLOW_WRITE_WAVE = '{8'h01, 8'h01, 8'h00, 8'h03, 8'h03};

  // User-programmed timing
  typedef struct packed {
    wave_s      rd;
    wave_s      wr;
    logic [1:0] wait_input_mode;
  } smc_cfg_s;

  // Host access to the command window
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } host_rsp_s;

  // NAND side outputs
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [7:0] chip_select_strobe_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nand_pins_s;

  // Sequencer steps
  typedef enum logic [2:0] {ST_IDLE, ST_FIRST_COMMAND_BYTE, ST_ADDR, ST_SECOND_COMMAND_BYTE, ST_DATA} seq_e;

endpackage

// ---- rtl/page_ram.sv ----
// Single-port page buffer with registered read data
`timescale 1ns/1ns
module page_ram
  import nand_seq_pkg::*;
#(
  parameter int DEPTH = 4096,
  parameter int AW    = 12
) (
  // Clock
  input  wire logic          mclk,
  // Access
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  // Read before write, read registered
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ---- tb/nand_flash_model.sv ----
// Behavioural NAND flash device on the far side of the sequencer pins
`timescale 1ns/1ns
module nand_flash_model
  import nand_seq_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Device pins
  input  wire nand_pins_s pins,
  output logic [7:0]      io_in,
  output logic            wait_n
);
  logic [7:0] lat_q[$];
  logic [7:0] dat_q[$];
  logic [7:0] rd_val = 8'h3f;
  nand_pins_s prev;
  int         cs_run = 0;
  int         cs_len = 0;
  int         we_run = 0;
  int         we_len = 0;
  int         re_run = 0;
  int         re_len = 0;
  int         wait_len = 0;
  int         wait_left = 0;
  logic [7:0] cs_seen = 8'hff;

  // Wait held low for wait_len cycles after each write strobe fall
  assign wait_n = (wait_left == 0);
  // Page data while selected, inverted last value once released
  assign io_in = (&pins.chip_select_strobe_n) ? ~rd_val : rd_val;

  // Latch bytes on write strobe rise, step page data on read strobe fall, time the strobes
  always @(posedge mclk) begin
    prev <= pins;
    if (!prev.write_strobe_n && pins.write_strobe_n) begin
      if (prev.cle || prev.ale) lat_q.push_back(prev.io_out);
      else dat_q.push_back(prev.io_out);
    end
    if (prev.cle && !pins.cle) rd_val <= 8'h3f;
    else if (prev.read_strobe_n && !pins.read_strobe_n) rd_val <= rd_val + 8'h01;
    cs_run <= (&pins.chip_select_strobe_n) ? 0 : cs_run + 1;
    if ((&pins.chip_select_strobe_n) && cs_run > 0) cs_len <= cs_run;
    we_run <= pins.write_strobe_n ? 0 : we_run + 1;
    if (pins.write_strobe_n && we_run > 0) we_len <= we_run;
    re_run <= pins.read_strobe_n ? 0 : re_run + 1;
    if (pins.read_strobe_n && re_run > 0) re_len <= re_run;
    if (prev.write_strobe_n && !pins.write_strobe_n) wait_left <= wait_len;
    else if (wait_left > 0) wait_left <= wait_left - 1;
    if (!(&pins.chip_select_strobe_n)) cs_seen <= pins.chip_select_strobe_n;
  end
endmodule

// ---- tb/nand_cmd_seq_tb.sv ----
// Self-checking bench for the NAND command sequencer
`timescale 1ns/1ns
module nand_cmd_seq_tb
  import nand_seq_pkg::*;
;
  localparam wave_s NORM_RD = '{8'h01, 8'h02, 8'h00, 8'h08, 8'h08};
  localparam wave_s NORM_WR = '{8'h01, 8'h02, 8'h00, 8'h04, 8'h04};
  localparam wave_s LONG_WR = '{8'h01, 8'h06, 8'h00, 8'h0a, 8'h0a};

  logic       mclk;
  logic       rst_n;
  host_req_s  host_req;
  host_rsp_s  host_rsp;
  smc_cfg_s   cfg;
  logic       slow_clock_mode;
  logic [7:0] address_byte_zero;
  logic [3:0] buf_addr;
  logic       buf_we;
  logic [7:0] buf_wdata;
  logic [7:0] buf_rdata;
  logic       wait_n;
  logic [7:0] io_in;
  nand_pins_s nand_pins;
  logic       busy;
  int         num_errors = 0;
  int         total_checks = 0;

  nand_cmd_seq #(.PAGE_BYTES(16), .AW(4)) i_nand_cmd_seq (
    .mclk(mclk), .rst_n(rst_n), .host_req(host_req), .host_rsp(host_rsp), .cfg(cfg),
    .slow_clock_mode(slow_clock_mode), .address_byte_zero(address_byte_zero),
    .buf_addr(buf_addr), .buf_we(buf_we), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
    .external_wait_in_n(wait_n), .nand_io_in(io_in), .nand_pins(nand_pins), .busy(busy));

  nand_flash_model i_nand_flash_model (.mclk(mclk), .pins(nand_pins), .io_in(io_in),
    .wait_n(wait_n));

  // Master clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
    chk(exp.size(), got.size());
    foreach (exp[i]) chk(exp[i], got[i]);
  endtask

  // Build a command window address from its fields
  function automatic logic [31:0] mk(input logic [7:0] c1, input logic [7:0] c2,
      input logic v2, input logic [2:0] ac, input logic xe, input logic wd,
      input logic [2:0] cs);
    mk = CMD_WINDOW_BASE;
    mk[FIRST_COMMAND_BYTE_HI:FIRST_COMMAND_BYTE_LO] = c1;
    mk[SECOND_COMMAND_BYTE_HI:SECOND_COMMAND_BYTE_LO] = c2;
    mk[SECOND_COMMAND_BYTE_VALID_BIT] = v2;
    mk[ACYC_HI:ACYC_LO] = ac;
    mk[XFER_EN_BIT] = xe;
    mk[WR_DIR_BIT] = wd;
    mk[CS_HI:CS_LO] = cs;
  endfunction

  // One host access; answer is due one edge after the request is taken
  task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge mclk);
    host_req <= '{1'b1, wr, a, d};
    @(posedge mclk);
    host_req.req <= 1'b0;
    #1;
    chk(32'h1, host_rsp.ack);
    r = host_rsp.rdata;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge mclk);
      n++;
      if (n > 3000) begin
        num_errors++;
        finish_test();
      end
    end
  endtask

  task automatic t_reset();
    logic [31:0] r;
    access(1'b0, CMD_WINDOW_BASE + 32'h0100_0000, 32'h0, r);
    chk(STATUS_RESET, r);
    access(1'b0, EXT_MEM_BASE, 32'h0, r);
    chk(32'h0, r);
    access(1'b1, EXT_MEM_BASE | 32'h0400_0000, 32'h1, r);
    chk(32'h0, busy);
  endtask

  task automatic t_cmd();
    logic [31:0] w;
    logic [31:0] r;
    w = mk(8'h60, 8'hd0, 1'b1, 3'h3, 1'b0, 1'b0, 3'h2);
    i_nand_flash_model.lat_q.delete();
    access(1'b1, w, 32'h4433_2211, r);
    chk(32'h1, busy);
    access(1'b0, CMD_WINDOW_BASE | 32'h0000_0040, 32'h0, r);
    chk(w & 32'h0fff_fffc, r);
    access(1'b0, EXT_MEM_BASE, 32'h0, r);
    chk(32'h0, r);
    wait_idle();
    access(1'b0, CMD_WINDOW_BASE, 32'h0, r);
    chk(w & 32'h07ff_fffc, r);
    chk_q(i_nand_flash_model.lat_q, {8'h60, 8'h11, 8'h22, 8'h33, 8'hd0});
    chk(32'h4, i_nand_flash_model.cs_len);
    chk(32'h2, i_nand_flash_model.we_len);
    chk(32'hfb, i_nand_flash_model.cs_seen);
  endtask

  task automatic t_five_back_to_back();
    logic [31:0] r;
    i_nand_flash_model.lat_q.delete();
    access(1'b1, mk(8'h00, 8'h30, 1'b1, 3'h5, 1'b0, 1'b0, 3'h0), 32'h4433_2211, r);
    access(1'b1, mk(8'hff, 8'h77, 1'b0, 3'h0, 1'b0, 1'b0, 3'h0), 32'h0, r);
    wait_idle();
    chk_q(i_nand_flash_model.lat_q,
      {8'h00, 8'h5a, 8'h11, 8'h22, 8'h33, 8'h44, 8'h30, 8'hff});
  endtask

  task automatic t_slow();
    logic [31:0] r;
    @(posedge mclk);
    slow_clock_mode <= 1'b1;
    access(1'b1, mk(8'h90, 8'h00, 1'b0, 3'h1, 1'b0, 1'b0, 3'h5), 32'h0, r);
    wait_idle();
    chk(32'h3, i_nand_flash_model.cs_len);
    chk(32'h1, i_nand_flash_model.we_len);
    chk(32'hdf, i_nand_flash_model.cs_seen);
    access(1'b1, mk(8'h00, 8'h30, 1'b1, 3'h1, 1'b1, 1'b0, 3'h5), 32'h0, r);
    wait_idle();
    chk(32'h2, i_nand_flash_model.cs_len);
    chk(32'h1, i_nand_flash_model.re_len);
    @(posedge mclk);
    slow_clock_mode <= 1'b0;
  endtask

  // Device holds wait three cycles after each write strobe fall
  task automatic t_wait();
    logic [31:0] r;
    @(posedge mclk);
    cfg <= '{NORM_RD, NORM_WR, WAIT_MODE_FROZEN};
    i_nand_flash_model.wait_len <= 3;
    access(1'b1, mk(8'h70, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 3'h3), 32'h0, r);
    wait_idle();
    chk(32'h2, i_nand_flash_model.we_len);
    chk(32'h4, i_nand_flash_model.cs_len);
    @(posedge mclk);
    cfg <= '{NORM_RD, LONG_WR, WAIT_MODE_FROZEN};
    access(1'b1, mk(8'h70, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 3'h3), 32'h0, r);
    wait_idle();
    chk(32'h9, i_nand_flash_model.we_len);
    chk(32'hd, i_nand_flash_model.cs_len);
    @(posedge mclk);
    cfg <= '{NORM_RD, LONG_WR, WAIT_MODE_READY};
    access(1'b1, mk(8'h70, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0, 3'h3), 32'h0, r);
    wait_idle();
    chk(32'h7, i_nand_flash_model.we_len);
    chk(32'hb, i_nand_flash_model.cs_len);
    @(posedge mclk);
    cfg <= '{NORM_RD, NORM_WR, WAIT_MODE_OFF};
    i_nand_flash_model.wait_len <= 0;
  endtask

  task automatic t_read_page();
    logic [31:0] r;
    access(1'b1, mk(8'h00, 8'h30, 1'b1, 3'h1, 1'b1, 1'b0, 3'h1), 32'h0, r);
    wait_idle();
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      buf_addr <= 4'(i);
      @(posedge mclk);
      #1;
      chk(8'h40 + 8'(i), buf_rdata);
    end
  endtask

  task automatic t_write_page();
    logic [31:0] r;
    logic [7:0]  e[$];
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      buf_we <= 1'b1;
      buf_addr <= 4'(i);
      buf_wdata <= 8'hc0 + 8'(i);
      e.push_back(8'hc0 + 8'(i));
    end
    @(posedge mclk);
    buf_we <= 1'b0;
    i_nand_flash_model.dat_q.delete();
    access(1'b1, mk(8'h80, 8'h10, 1'b1, 3'h1, 1'b1, 1'b1, 3'h1), 32'h0, r);
    wait_idle();
    chk_q(i_nand_flash_model.dat_q, e);
  endtask

  // Main sequence
  initial begin
    host_req <= '0;
    cfg <= '{NORM_RD, NORM_WR, WAIT_MODE_OFF};
    slow_clock_mode <= 1'b0;
    address_byte_zero <= 8'h5a;
    buf_addr <= 4'h0;
    buf_we <= 1'b0;
    buf_wdata <= 8'h00;
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_cmd();
    t_five_back_to_back();
    t_slow();
    t_wait();
    t_read_page();
    t_write_page();
    finish_test();
  end
endmodule
